// ==== pewc_defines.svh ====
// constants for the parallel eeprom page write controller
// Behaviour
// - write starts on write strobe low pulse, chip select low, output enable high
// - page load takes one to 64 bytes programmed together
// - host presents each next page byte within 100 us of the last
// - host keeps address bits 6 to 12 constant within one page load
// - each write operation opens with a three-write protection sequence
`ifndef PEWC_DEFINES_SVH
`define PEWC_DEFINES_SVH
`define PEWC_CLK_PERIOD_NS 4
`define PEWC_ADDR_W 13
`define PEWC_PAGE_BYTES 64
`define PEWC_PAGE_LSB 6
`define PEWC_IDENT_TOP 13'h003F
`define PEWC_SDP_ADDR0 13'h1555
`define PEWC_SDP_DATA0 8'hAA
`define PEWC_SDP_ADDR1 13'h0AAA
`define PEWC_SDP_DATA1 8'h55
`define PEWC_SDP_ADDR2 13'h1555
`define PEWC_SDP_DATA2 8'hA0
`define PEWC_WP_NS 200
`define PEWC_WPH_NS 100
`define PEWC_ACC_NS 200
`define PEWC_DF_NS 55
`define PEWC_WP_CYC ((`PEWC_WP_NS + `PEWC_CLK_PERIOD_NS - 1) / `PEWC_CLK_PERIOD_NS)
`define PEWC_WPH_CYC ((`PEWC_WPH_NS + `PEWC_CLK_PERIOD_NS - 1) / `PEWC_CLK_PERIOD_NS)
`define PEWC_ACC_CYC ((`PEWC_ACC_NS + `PEWC_CLK_PERIOD_NS - 1) / `PEWC_CLK_PERIOD_NS + 2)
`define PEWC_DF_CYC ((`PEWC_DF_NS + `PEWC_CLK_PERIOD_NS - 1) / `PEWC_CLK_PERIOD_NS)
`define PEWC_BLC_US 100
`define PEWC_BLC_CYC ((`PEWC_BLC_US * 1000) / `PEWC_CLK_PERIOD_NS)
`define PEWC_WC_MS 10
`define PEWC_WC_CYC ((`PEWC_WC_MS * 1000000) / `PEWC_CLK_PERIOD_NS)
`define PEWC_PON_MS 10
`define PEWC_PON_CYC ((`PEWC_PON_MS * 1000000) / `PEWC_CLK_PERIOD_NS)
`endif

// ==== pewc_pkg.sv ====
// types for the parallel eeprom page write controller
package pewc_pkg;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic ident;
		logic [12:0] addr;
	} pewc_pins_t;
	typedef enum logic [3:0] {
		PEWC_POWERUP = 4'h0,
		PEWC_IDLE = 4'h1,
		PEWC_WSETUP = 4'h2,
		PEWC_WPULSE = 4'h3,
		PEWC_WHIGH = 4'h4,
		PEWC_RSETUP = 4'h5,
		PEWC_RWAIT = 4'h6,
		PEWC_RFLOAT = 4'h7,
		PEWC_POLL = 4'h8,
		PEWC_PGAP = 4'h9
	} pewc_state_t;
endpackage

// ==== pewc_ctrl.sv ====
// host controller driving the parallel eeprom pins
`timescale 1ns/100ps
`include "pewc_defines.svh"
module pewc_ctrl
	import pewc_pkg::*;
#(
	parameter int BLC_CYC = `PEWC_BLC_CYC,
	parameter int WC_CYC = `PEWC_WC_CYC,
	parameter int PON_CYC = `PEWC_PON_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic i_req_last,
	input wire logic i_req_ident,
	input wire logic [12:0] i_req_addr,
	input wire logic [7:0] i_req_data,
	output logic o_req_ready,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic o_busy,
	output logic o_timeout,
	output pewc_pins_t o_pins,
	output logic [7:0] o_data_bus_o,
	output logic o_data_bus_oe,
	input wire logic [7:0] i_data_bus_i
);
	localparam int CW = 32;
	pewc_state_t st_r, st_nxt;
	pewc_pins_t pins_r, pins_nxt;
	logic [7:0] dout_r, dout_nxt, rd_r, rd_nxt;
	logic oe_r, oe_nxt, rdv_r, rdv_nxt, last_r, last_nxt, to_r, to_nxt;
	logic [1:0] seq_r, seq_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt, win_r, win_nxt, wc_r, wc_nxt;
	logic [7:0] tgt_r, tgt_nxt, prev_r, prev_nxt;
	logic [12:0] tadr_r, tadr_nxt;
	logic first_r, first_nxt;
	logic [7:0] sync1_r, sync2_r;
	logic [12:0] cmd_addr;
	logic [7:0] cmd_data;
	// pin inputs cross in through two flops
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= i_data_bus_i;
			sync2_r <= sync1_r;
		end
	end
	always_comb begin
		cmd_addr = (seq_r == 2'd0) ? `PEWC_SDP_ADDR0 : (seq_r == 2'd1) ? `PEWC_SDP_ADDR1 : `PEWC_SDP_ADDR2;
		cmd_data = (seq_r == 2'd0) ? `PEWC_SDP_DATA0 : (seq_r == 2'd1) ? `PEWC_SDP_DATA1 : `PEWC_SDP_DATA2;
	end
	// only a page byte is taken mid-load, and never once the window has closed
	assign o_req_ready = (st_r == PEWC_IDLE) || (st_r == PEWC_PGAP && seq_r == 2'd3 && win_r != '0 && i_req_write);
	always_comb begin
		st_nxt = st_r;
		pins_nxt = pins_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		rd_nxt = rd_r;
		rdv_nxt = 1'b0;
		last_nxt = last_r;
		to_nxt = to_r;
		seq_nxt = seq_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		win_nxt = (win_r != '0) ? win_r - 1'b1 : win_r;
		wc_nxt = (wc_r != '0) ? wc_r - 1'b1 : wc_r;
		tgt_nxt = tgt_r;
		tadr_nxt = tadr_r;
		prev_nxt = prev_r;
		first_nxt = first_r;
		case (st_r)
			PEWC_POWERUP: begin
				if (cnt_r == '0) begin
					st_nxt = PEWC_IDLE;
				end
			end
			PEWC_IDLE: begin
				if (i_req_valid) begin
					pins_nxt.ident = i_req_ident;
					last_nxt = i_req_last;
					if (i_req_write) begin
						// a fresh operation always opens with the protection words
						seq_nxt = 2'd0;
						pins_nxt.addr = `PEWC_SDP_ADDR0;
						dout_nxt = `PEWC_SDP_DATA0;
						tadr_nxt = i_req_addr;
						tgt_nxt = i_req_data;
						st_nxt = PEWC_WSETUP;
					end else begin
						pins_nxt.addr = i_req_addr;
						st_nxt = PEWC_RSETUP;
					end
				end
			end
			PEWC_PGAP: begin
				// host must feed next byte before the load window closes
				if (win_r == '0) begin
					to_nxt = 1'b1;
					first_nxt = 1'b1;
					wc_nxt = CW'(WC_CYC);
					st_nxt = PEWC_POLL;
				end else if (seq_r != 2'd3) begin
					pins_nxt.addr = cmd_addr;
					dout_nxt = cmd_data;
					st_nxt = PEWC_WSETUP;
				end else if (i_req_valid && i_req_write) begin
					to_nxt = 1'b0;
					last_nxt = i_req_last;
					// only the low six bits may move inside a load
					pins_nxt.addr = {tadr_r[12:`PEWC_PAGE_LSB], i_req_addr[`PEWC_PAGE_LSB-1:0]};
					tadr_nxt = {tadr_r[12:`PEWC_PAGE_LSB], i_req_addr[`PEWC_PAGE_LSB-1:0]};
					dout_nxt = i_req_data;
					tgt_nxt = i_req_data;
					st_nxt = PEWC_WSETUP;
				end else if (i_req_valid) begin
					to_nxt = 1'b1; // a read mid-load closes the page early
					first_nxt = 1'b1;
					wc_nxt = CW'(WC_CYC);
					st_nxt = PEWC_POLL;
				end
			end
			PEWC_WSETUP: begin
				// address settles with output enable high before the strobe falls
				oe_nxt = 1'b1;
				pins_nxt.oe_n = 1'b1;
				pins_nxt.ce_n = 1'b0;
				pins_nxt.we_n = 1'b0;
				cnt_nxt = CW'(`PEWC_WP_CYC);
				st_nxt = PEWC_WPULSE;
			end
			PEWC_WPULSE: begin
				// pulse held well above the noise filter width
				if (cnt_r == '0) begin
					pins_nxt.we_n = 1'b1;
					cnt_nxt = CW'(`PEWC_WPH_CYC);
					st_nxt = PEWC_WHIGH;
				end
			end
			PEWC_WHIGH: begin
				if (cnt_r == '0) begin
					pins_nxt.ce_n = 1'b1;
					oe_nxt = 1'b0;
					win_nxt = CW'(BLC_CYC);
					if (seq_r != 2'd3) begin
						seq_nxt = seq_r + 2'd1;
					end
					if (seq_r == 2'd3 && last_r) begin
						first_nxt = 1'b1;
						wc_nxt = CW'(WC_CYC);
						st_nxt = PEWC_POLL;
					end else if (seq_r == 2'd2) begin
						pins_nxt.addr = {tadr_r[12:`PEWC_PAGE_LSB], tadr_r[`PEWC_PAGE_LSB-1:0]};
						dout_nxt = tgt_r;
						seq_nxt = 2'd3;
						st_nxt = PEWC_WSETUP;
					end else begin
						st_nxt = PEWC_PGAP;
					end
				end
			end
			PEWC_POLL: begin
				// poll the last byte: bit 7 true and bit 6 steady mean done
				pins_nxt.addr = tadr_r;
				pins_nxt.ce_n = 1'b0;
				pins_nxt.oe_n = 1'b0;
				cnt_nxt = CW'(`PEWC_ACC_CYC);
				st_nxt = PEWC_RWAIT;
			end
			PEWC_RSETUP: begin
				pins_nxt.ce_n = 1'b0;
				pins_nxt.oe_n = 1'b0;
				cnt_nxt = CW'(`PEWC_ACC_CYC);
				st_nxt = PEWC_RWAIT;
			end
			PEWC_RWAIT: begin
				if (cnt_r == '0) begin
					pins_nxt.ce_n = 1'b1;
					pins_nxt.oe_n = 1'b1;
					cnt_nxt = CW'(`PEWC_DF_CYC);
					st_nxt = PEWC_RFLOAT;
					if (seq_r == 2'd3) begin
						prev_nxt = sync2_r;
						first_nxt = 1'b0;
						if ((sync2_r[7] == tgt_r[7] && !first_r && sync2_r[6] == prev_r[6]) || wc_r == '0) begin
							seq_nxt = 2'd0;
						end
					end else begin
						rd_nxt = sync2_r;
						rdv_nxt = 1'b1;
					end
				end
			end
			PEWC_RFLOAT: begin
				if (cnt_r == '0) begin
					st_nxt = (seq_r == 2'd3) ? PEWC_POLL : PEWC_IDLE;
				end
			end
			default: begin
				st_nxt = PEWC_IDLE;
			end
		endcase
	end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_r <= PEWC_POWERUP;
			pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, ident: 1'b0, addr: 13'h0000};
			dout_r <= 8'h00;
			oe_r <= 1'b0;
			rd_r <= 8'h00;
			rdv_r <= 1'b0;
			last_r <= 1'b0;
			to_r <= 1'b0;
			seq_r <= 2'd0;
			cnt_r <= CW'(PON_CYC);
			win_r <= '0;
			wc_r <= '0;
			tgt_r <= 8'h00;
			tadr_r <= 13'h0000;
			prev_r <= 8'h00;
			first_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pins_r <= pins_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			rd_r <= rd_nxt;
			rdv_r <= rdv_nxt;
			last_r <= last_nxt;
			to_r <= to_nxt;
			seq_r <= seq_nxt;
			cnt_r <= cnt_nxt;
			win_r <= win_nxt;
			wc_r <= wc_nxt;
			tgt_r <= tgt_nxt;
			tadr_r <= tadr_nxt;
			prev_r <= prev_nxt;
			first_r <= first_nxt;
		end
	end
	assign o_pins = pins_r;
	assign o_data_bus_o = dout_r;
	assign o_data_bus_oe = oe_r;
	assign o_rd_valid = rdv_r;
	assign o_rd_data = rd_r;
	assign o_busy = (st_r != PEWC_IDLE);
	assign o_timeout = to_r;
	// never drive data while the device may drive it
	host_drive_a: assert property (@(posedge i_clk) disable iff (i_reset) o_data_bus_oe |-> o_pins.oe_n)
		else $error("host drives data with output enable low");
	write_inhibit_a: assert property (@(posedge i_clk) disable iff (i_reset) !o_pins.we_n |-> !o_pins.ce_n && o_pins.oe_n)
		else $error("write strobe low without chip select or with output enable");
	strobe_width_a: assert property (@(posedge i_clk) disable iff (i_reset) $fell(o_pins.we_n) |-> !o_pins.we_n [*8])
		else $error("write pulse too short");
	page_row_a: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(o_pins.we_n) && seq_r == 2'd3 |-> o_pins.addr[12:6] == tadr_r[12:6])
		else $error("page row moved inside a load");
	powerup_hold_a: assert property (@(posedge i_clk) disable iff (i_reset) st_r == PEWC_POWERUP |-> o_pins.we_n)
		else $error("write during power-on delay");
	data_stable_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!o_pins.we_n && !$past(o_pins.we_n) |-> $stable(o_data_bus_o) && $stable(o_pins.addr))
		else $error("address or data moved under strobe");
	read_drive_a: assert property (@(posedge i_clk) disable iff (i_reset) !o_pins.oe_n |-> !o_pins.ce_n && o_pins.we_n)
		else $error("read cycle with bad strobes");
	sdp_open_a: assert property (@(posedge i_clk) disable iff (i_reset)
		st_r == PEWC_IDLE && i_req_valid && i_req_write |=> o_pins.addr == `PEWC_SDP_ADDR0 && o_data_bus_o == `PEWC_SDP_DATA0)
		else $error("write not opened by protection word");
	pulse_end_a: assert property (@(posedge i_clk) disable iff (i_reset) $rose(o_pins.we_n) |-> !o_pins.ce_n)
		else $error("chip select rose before write strobe");
endmodule // pewc_ctrl

// ==== pewc_dev_model.sv ====
// behavioural parallel eeprom answering the controller pins
`timescale 1ns/100ps
`include "pewc_defines.svh"
module pewc_dev_model
	import pewc_pkg::*;
#(
	parameter int PROG_CYC = 300,
	parameter int BLC_CYC = 200,
	parameter int PON_CYC = 40
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire pewc_pins_t i_pins,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data
);
	logic [7:0] mem [8192];
	logic [7:0] idm [64];
	logic [7:0] pg [64];
	logic [12:0] sa [3] = '{`PEWC_SDP_ADDR0, `PEWC_SDP_ADDR1, `PEWC_SDP_ADDR2};
	logic [7:0] sd [3] = '{`PEWC_SDP_DATA0, `PEWC_SDP_DATA1, `PEWC_SDP_DATA2};
	logic [63:0] ld = '0;
	logic [12:0] a = '0, pa = '0;
	logic [7:0] last = '0, lv = '0;
	logic tog = 1'b0, id = 1'b0, wr, rd, bsy;
	int step = 0, wcnt = 0, pcnt = 0, pon = 0;
	realtime t0 = 0;
	initial for (int k = 0; k < 8192; k++) begin
		mem[k] = 8'hff;
		idm[k % 64] = 8'hff;
	end
	assign wr = !i_pins.ce_n && !i_pins.we_n && i_pins.oe_n;
	assign rd = !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;
	assign bsy = pcnt > 0 || ld != '0;
	always @(posedge wr) begin
		a = i_pins.addr;
		t0 = $realtime;
	end
	// glitches and early writes vanish with no side effect
	always @(negedge wr) begin
		if (pon == 0 && pcnt == 0 && $realtime - t0 >= 15.0) begin
			wcnt = BLC_CYC;
			last = i_data;
			if (step < 3 && a == sa[step] && i_data == sd[step]) step++;
			else if (step < 3) pcnt = PROG_CYC;
			else begin
				pg[a[5:0]] = i_data;
				ld[a[5:0]] = 1'b1;
				pa = a;
				id = i_pins.ident;
			end
		end
	end
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pon = PON_CYC;
			pcnt = 0;
			wcnt = 0;
			step = 0;
			ld = '0;
		end else begin
			if (pon > 0) pon--;
			if (wcnt == 1) begin
				step = 0;
				if (ld != '0) pcnt = PROG_CYC;
			end
			if (wcnt > 0) wcnt--;
			if (pcnt == 1) begin
				for (int k = 0; k < 64; k++) if (ld[k]) begin
					if (id && pa[12:6] == 7'h00) idm[k] = pg[k];
					else mem[{pa[12:6], 6'(k)}] = pg[k];
				end
				ld = '0;
			end
			if (pcnt > 0) pcnt--;
		end
	end
	always @(posedge rd) if (bsy) tog = ~tog;
	always @(negedge rd) lv = o_data;
	// no pull on the bus, so a released line shows the inverse
	always @* begin
		if (!rd) o_data = ~lv;
		else if (bsy) o_data = {~last[7], tog, last[5:0]};
		else if (i_pins.ident && i_pins.addr[12:6] == 7'h00) o_data = idm[i_pins.addr[5:0]];
		else o_data = mem[i_pins.addr];
	end
endmodule // pewc_dev_model

// ==== tb.sv ====
// testbench for the eeprom page write controller
`timescale 1ns/100ps
`include "pewc_defines.svh"
module tb;
	import pewc_pkg::*;
	logic i_clk = 1'b0, i_reset = 1'b1, v = 1'b0, w = 1'b0, lst = 1'b0, idn = 1'b0;
	logic [12:0] ad = '0;
	logic [7:0] dt = '0, bus, m_o, d_o, rdd;
	logic rdy, rv, bsy, tmo, d_oe;
	pewc_pins_t pins;
	int mismatches = 0, n_tests = 0;
	always #2 i_clk = ~i_clk;
	assign bus = d_oe ? d_o : m_o;
	pewc_ctrl #(.BLC_CYC(200), .WC_CYC(2000), .PON_CYC(50)) pewc_ctrl_i (.i_clk(i_clk), .i_reset(i_reset),
		.i_req_valid(v), .i_req_write(w), .i_req_last(lst), .i_req_ident(idn), .i_req_addr(ad), .i_req_data(dt),
		.o_req_ready(rdy), .o_rd_valid(rv), .o_rd_data(rdd), .o_busy(bsy), .o_timeout(tmo), .o_pins(pins),
		.o_data_bus_o(d_o), .o_data_bus_oe(d_oe), .i_data_bus_i(bus));
	pewc_dev_model pewc_dev_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_pins(pins), .i_data(bus), .o_data(m_o));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (e !== g) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (e !== g) begin
			mismatches++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	// bounded wait on ready (0) or read valid (1)
	task automatic till(input int s);
		int n;
		n = 0;
		while ((s == 0 ? rdy : rv) !== 1'b1) begin
			@(negedge i_clk);
			n++;
			if (n > 9000) begin
				chk1("wait_bound", 1'b1, 1'b0);
				report_and_stop();
			end
		end
	endtask
	task automatic req(input logic wr, input logic lt, input logic ix, input logic [12:0] a, input logic [7:0] d);
		@(negedge i_clk);
		v = 1'b1;
		w = wr;
		lst = lt;
		idn = ix;
		ad = a;
		dt = d;
		till(0);
		@(negedge i_clk);
		v = 1'b0;
	endtask
	task automatic rchk(input string nm, input logic ix, input logic [12:0] a, input logic [7:0] e);
		req(1'b0, 1'b0, ix, a, 8'h00);
		till(1);
		chk8(nm, e, rdd);
	endtask
	task automatic t_byte();
		req(1'b1, 1'b1, 1'b0, 13'h0123, 8'h5a);
		rchk("byte_0123", 1'b0, 13'h0123, 8'h5a);
		$display("byte test done");
	endtask
	task automatic t_page();
		req(1'b1, 1'b0, 1'b0, 13'h0847, 8'h11);
		req(1'b1, 1'b0, 1'b0, 13'h0841, 8'h22);
		req(1'b1, 1'b0, 1'b0, 13'h0847, 8'h33);
		req(1'b1, 1'b1, 1'b0, 13'h0842, 8'h44);
		rchk("page_0847", 1'b0, 13'h0847, 8'h33);
		rchk("page_0841", 1'b0, 13'h0841, 8'h22);
		rchk("page_0842", 1'b0, 13'h0842, 8'h44);
		rchk("page_0843", 1'b0, 13'h0843, 8'hff);
		$display("page test done");
	endtask
	task automatic t_window();
		req(1'b1, 1'b0, 1'b0, 13'h0200, 8'h66);
		// three protection words and the byte come first, then the window runs out
		repeat (700) @(negedge i_clk);
		chk1("timeout", 1'b1, tmo);
		rchk("window_0200", 1'b0, 13'h0200, 8'h66);
		$display("window test done");
	endtask
	task automatic t_ident();
		req(1'b1, 1'b1, 1'b1, 13'h0005, 8'hc3);
		rchk("ident_0005", 1'b1, 13'h0005, 8'hc3);
		rchk("main_0005", 1'b0, 13'h0005, 8'hff);
		$display("ident test done");
	endtask
	task automatic t_cmd();
		rchk("cmd_addr0", 1'b0, `PEWC_SDP_ADDR0, 8'hff);
		rchk("cmd_addr1", 1'b0, `PEWC_SDP_ADDR1, 8'hff);
		$display("command test done");
	endtask
	initial begin
		repeat (20) @(negedge i_clk);
		chk1("we_n_reset", 1'b1, pins.we_n);
		chk1("busy_reset", 1'b1, bsy);
		i_reset = 1'b0;
		repeat (45) @(negedge i_clk);
		chk1("ready_early", 1'b0, rdy);
		t_byte();
		t_page();
		t_window();
		t_ident();
		t_cmd();
		report_and_stop();
	end
endmodule // tb
